/* File: timer_mode_pkg.sv */
/*
 * constants, field layouts and carrier types for the timer channel mode control.
 * assumes a 32-bit AXI4-Lite register bus and one synchronous clock domain.
 */
`default_nettype none

package timer_mode_pkg;

    // register byte offsets
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  MODE_OFS    = 8'h00;
    localparam logic [7:0]  CTRL_OFS    = 8'h04;
    localparam logic [7:0]  PERIOD_OFS  = 8'h08;
    localparam logic [7:0]  COUNT_OFS   = 8'h0C;
    localparam logic [7:0]  CAPTURE_OFS = 8'h10;
    localparam logic [7:0]  STATUS_OFS  = 8'h14;

    // mode register reset value and writable bits (13, 5 and 4 read zero)
    localparam logic [15:0] MODE_RESET  = 16'h0000;
    localparam logic [15:0] MODE_WMASK  = 16'hDFCF;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    // control and status bit positions
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_STOP_BIT  = 1;
    localparam int unsigned STAT_RUN_BIT   = 0;
    localparam int unsigned STAT_OUT_BIT   = 1;
    localparam int unsigned STAT_UP_BIT    = 2;

    // trigger select encodings
    localparam logic [2:0] TRIG_SW     = 3'h0;
    localparam logic [2:0] TRIG_EDGE   = 3'h1;
    localparam logic [2:0] TRIG_BOTH   = 3'h2;
    localparam logic [2:0] TRIG_MASTER = 3'h4;

    // operating modes, mode bits 3 to 1
    localparam logic [2:0] OP_INTERVAL = 3'h0;
    localparam logic [2:0] OP_CAPTURE  = 3'h2;
    localparam logic [2:0] OP_EVENT    = 3'h3;
    localparam logic [2:0] OP_ONE      = 3'h4;
    localparam logic [2:0] OP_CAP_ONE  = 3'h6;

    // input valid edge encodings
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // channel mode register layout, bit 15 first
    typedef struct packed {
        logic [1:0] prescaler_select;
        logic       zero13;
        logic       count_clock_select;
        logic       width_split_select;
        logic [2:0] trigger_select;
        logic [1:0] input_edge_select;
        logic [1:0] zero5_4;
        logic [2:0] mode_op;
        logic       start_interrupt_option;
    } mode_fields_t;

    // qualified edges of the channel input pin
    typedef struct packed {
        logic valid_edge;
        logic any_edge;
        logic end_edge;
    } pin_edges_t;

endpackage

`default_nettype wire

/* File: pin_edge_detect.sv */
/*
 * channel input pin synchroniser and edge qualifier.
 * assumes the pin is asynchronous to aclk; the caller gives the edge select.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    ce,
    input  wire logic                    channel_input_pin,
    input  wire logic [1:0]              edge_sel,
    output var  timer_mode_pkg::pin_edges_t edges
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;
    logic        rise;
    logic        fall;

    // meta feeds only sync; edges look at sync and prev
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.meta = channel_input_pin;
        nxt_st.sync = st_ff.meta;
        nxt_st.prev = st_ff.sync;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

    // end edge is the opposite of the valid one, any edge when both are valid
    assign rise             = st_ff.sync & ~st_ff.prev;
    assign fall             = ~st_ff.sync & st_ff.prev;
    assign edges.any_edge   = rise | fall;
    assign edges.valid_edge = (edge_sel == timer_mode_pkg::EDGE_FALL) ? fall :
                              (edge_sel == timer_mode_pkg::EDGE_RISE) ? rise : (rise | fall);
    assign edges.end_edge   = (edge_sel == timer_mode_pkg::EDGE_FALL) ? rise :
                              (edge_sel == timer_mode_pkg::EDGE_RISE) ? fall : (rise | fall);

endmodule

`default_nettype wire

/* File: timer_channel_mode_control.sv */
/*
 * mode control and counter of one 16-bit timer channel behind an AXI4-Lite slave.
 * assumes aclk at 20 MHz, synchronous active-low reset, master interrupt from the
 * same clock domain and an asynchronous channel input pin.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - split clear: one 16-bit counter
// - split set: counter works as 8-bit
// - trigger 000: only software start counts
// - trigger 001: valid pin edge starts/captures
// - trigger 010: both pin edges start/capture
// - trigger 100: master interrupt triggers channel
// - mode 000: interval timer, counts down
// - mode 010: capture, counts up
// - mode 0110: event counter, counts down
// - mode 100: one-count, counts down
// - mode 1100: capture one-count, counts up
// - option set, interval or capture: start raises irq, toggles output
// - option clear: start raises nothing
// - option clear: retrigger ignored while counting
// - one-count option set: retrigger restarts, irq
// - count clock select: count pin edges
module timer_channel_mode_control
#(
    parameter int unsigned CNT_W   = 16,
    parameter int unsigned SPLIT_W = 8
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        channel_input_pin,
    input  wire logic        master_irq,
    output var  logic        timer_irq,
    output var  logic        timer_out
);

    localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);
    localparam logic [CNT_W-1:0] MASK_FULL  = '1;
    localparam logic [CNT_W-1:0] MASK_SPLIT = CNT_W'({SPLIT_W{1'b1}});

    typedef enum logic {IDLE, RUN} run_state_t;

    typedef struct packed {
        run_state_t                  state;
        timer_mode_pkg::mode_fields_t mode;
        logic [CNT_W-1:0]            period;
        logic [CNT_W-1:0]            count;
        logic [CNT_W-1:0]            capture;
        logic                        tout;
        logic                        irq;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [1:0]                  rresp;
        logic [31:0]                 rdata;
        logic                        aw_got;
        logic                        w_got;
        logic [7:0]                  aw_addr;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
    } chan_state_t;

    chan_state_t                 st_ff;
    chan_state_t                 nxt_st;
    timer_mode_pkg::pin_edges_t  edges;
    logic                        sw_start;
    logic                        sw_stop;
    logic                        hw_trig;
    logic                        tick;
    logic                        start_evt;
    logic                        opt;
    logic                        mode_legal;
    logic [2:0]                  op;
    logic [CNT_W-1:0]            cnt_mask;
    logic [CNT_W-1:0]            reload;

    pin_edge_detect u_pin
    (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .ce                (ce),
        .channel_input_pin (channel_input_pin),
        .edge_sel          (st_ff.mode.input_edge_select),
        .edges             (edges)
    );

    // mode decode shared by the sequencer and the checks
    always_comb
    begin
        op         = st_ff.mode.mode_op;
        opt        = st_ff.mode.start_interrupt_option;
        cnt_mask   = st_ff.mode.width_split_select ? MASK_SPLIT : MASK_FULL;
        reload     = st_ff.period & cnt_mask;
        tick       = st_ff.mode.count_clock_select ? edges.valid_edge : 1'b1;
        mode_legal = (op == timer_mode_pkg::OP_INTERVAL) || (op == timer_mode_pkg::OP_CAPTURE)
                  || (op == timer_mode_pkg::OP_ONE)
                  || ((op == timer_mode_pkg::OP_EVENT || op == timer_mode_pkg::OP_CAP_ONE) && !opt);
        // prohibited encodings select no source at all
        unique case (st_ff.mode.trigger_select)
            timer_mode_pkg::TRIG_SW:     hw_trig = 1'b0;
            timer_mode_pkg::TRIG_EDGE:   hw_trig = edges.valid_edge;
            timer_mode_pkg::TRIG_BOTH:   hw_trig = edges.any_edge;
            timer_mode_pkg::TRIG_MASTER: hw_trig = master_irq;
            default:                     hw_trig = 1'b0;
        endcase
    end

    // bus slave, register file and channel sequencer
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.irq = 1'b0;
        sw_start = 1'b0;
        sw_stop  = 1'b0;

        // ready is a one-cycle pulse, so a held valid is taken exactly once
        nxt_st.awready = s_axi_awvalid && !st_ff.aw_got && !st_ff.awready && !st_ff.bvalid;
        nxt_st.wready  = s_axi_wvalid && !st_ff.w_got && !st_ff.wready && !st_ff.bvalid;
        if (st_ff.awready && s_axi_awvalid)
        begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (st_ff.wready && s_axi_wvalid)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready)
            nxt_st.bvalid = 1'b0;
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = timer_mode_pkg::RESP_OKAY;
            case (st_ff.aw_addr)
                timer_mode_pkg::MODE_OFS:
                begin
                    for (int b = 0; b < 2; b++)
                        if (st_ff.wstrb[b])
                            nxt_st.mode[b*8 +: 8] = st_ff.wdata[b*8 +: 8]
                                                  & timer_mode_pkg::MODE_WMASK[b*8 +: 8];
                end
                timer_mode_pkg::PERIOD_OFS:
                begin
                    for (int b = 0; b < 2; b++)
                        if (st_ff.wstrb[b])
                            nxt_st.period[b*8 +: 8] = st_ff.wdata[b*8 +: 8];
                end
                timer_mode_pkg::CTRL_OFS:
                begin
                    sw_start = st_ff.wstrb[0] && st_ff.wdata[timer_mode_pkg::CTRL_START_BIT];
                    sw_stop  = st_ff.wstrb[0] && st_ff.wdata[timer_mode_pkg::CTRL_STOP_BIT];
                end
                timer_mode_pkg::COUNT_OFS,
                timer_mode_pkg::CAPTURE_OFS,
                timer_mode_pkg::STATUS_OFS: ;
                default: nxt_st.bresp = timer_mode_pkg::RESP_SLVERR;
            endcase
        end

        // read channel: address taken, data one cycle later
        nxt_st.arready = s_axi_arvalid && !st_ff.arready && !st_ff.rvalid;
        if (st_ff.rvalid && s_axi_rready)
            nxt_st.rvalid = 1'b0;
        if (st_ff.arready && s_axi_arvalid)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = timer_mode_pkg::RESP_OKAY;
            nxt_st.rdata  = '0;
            case (s_axi_araddr)
                timer_mode_pkg::MODE_OFS:    nxt_st.rdata = 32'(st_ff.mode);
                timer_mode_pkg::CTRL_OFS:    nxt_st.rdata = '0;
                timer_mode_pkg::PERIOD_OFS:  nxt_st.rdata = 32'(st_ff.period);
                timer_mode_pkg::COUNT_OFS:   nxt_st.rdata = 32'(st_ff.count);
                timer_mode_pkg::CAPTURE_OFS: nxt_st.rdata = 32'(st_ff.capture);
                timer_mode_pkg::STATUS_OFS:
                begin
                    nxt_st.rdata[timer_mode_pkg::STAT_RUN_BIT] = (st_ff.state == RUN);
                    nxt_st.rdata[timer_mode_pkg::STAT_OUT_BIT] = st_ff.tout;
                    nxt_st.rdata[timer_mode_pkg::STAT_UP_BIT]  =
                        (op == timer_mode_pkg::OP_CAPTURE) || (op == timer_mode_pkg::OP_CAP_ONE);
                end
                default: nxt_st.rresp = timer_mode_pkg::RESP_SLVERR;
            endcase
        end

        // software start is always honoured; hardware only through the selector
        start_evt = sw_start || hw_trig;

        unique case (st_ff.state)
            IDLE:
            begin
                if (start_evt && mode_legal)
                begin
                    nxt_st.state = RUN;
                    if (op == timer_mode_pkg::OP_CAPTURE || op == timer_mode_pkg::OP_CAP_ONE)
                        nxt_st.count = '0;
                    else
                        nxt_st.count = reload;
                    // start effect only for interval and capture with the option set
                    if (opt && (op == timer_mode_pkg::OP_INTERVAL
                             || op == timer_mode_pkg::OP_CAPTURE))
                    begin
                        nxt_st.irq  = 1'b1;
                        nxt_st.tout = ~st_ff.tout;
                    end
                end
            end
            RUN:
            begin
                if (sw_stop || !mode_legal)
                    nxt_st.state = IDLE;
                else if (op == timer_mode_pkg::OP_INTERVAL || op == timer_mode_pkg::OP_EVENT)
                begin
                    // down count with reload at zero
                    if (tick && st_ff.count == '0)
                    begin
                        nxt_st.count = reload;
                        nxt_st.irq   = 1'b1;
                        nxt_st.tout  = ~st_ff.tout;
                    end
                    else if (tick)
                        nxt_st.count = (st_ff.count - CNT_ONE) & cnt_mask;
                end
                else if (op == timer_mode_pkg::OP_CAPTURE)
                begin
                    // capture trigger latches the interval and restarts from zero
                    if (hw_trig)
                    begin
                        nxt_st.capture = st_ff.count;
                        nxt_st.count   = '0;
                        nxt_st.irq     = 1'b1;
                    end
                    else if (tick)
                        nxt_st.count = (st_ff.count + CNT_ONE) & cnt_mask;
                end
                else if (op == timer_mode_pkg::OP_ONE)
                begin
                    if (start_evt && opt)
                    begin
                        nxt_st.count = reload;
                        nxt_st.irq   = 1'b1;
                    end
                    else if (tick && st_ff.count == '0)
                    begin
                        nxt_st.state = IDLE;
                        nxt_st.irq   = 1'b1;
                        nxt_st.tout  = ~st_ff.tout;
                    end
                    else if (tick)
                        nxt_st.count = (st_ff.count - CNT_ONE) & cnt_mask;
                end
                else
                begin
                    // width measured to the opposite edge; retrigger ignored
                    if (edges.end_edge)
                    begin
                        nxt_st.capture = st_ff.count;
                        nxt_st.irq     = 1'b1;
                        nxt_st.state   = IDLE;
                    end
                    else if (tick)
                        nxt_st.count = (st_ff.count + CNT_ONE) & cnt_mask;
                end
            end
        endcase
        nxt_st.count = nxt_st.count & cnt_mask;
    end

    // low ce freezes everything, bus handshakes too
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff        <= '0;
            st_ff.state  <= IDLE;
            st_ff.mode   <= timer_mode_pkg::MODE_RESET;
            st_ff.period <= CNT_W'(timer_mode_pkg::PERIOD_RESET);
        end
        else if (ce)
            st_ff <= nxt_st;
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rresp   = st_ff.rresp;
    assign s_axi_rdata   = st_ff.rdata;
    assign timer_irq     = st_ff.irq;
    assign timer_out     = st_ff.tout;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start_effect;
        st_ff.irq && (st_ff.tout != $past(st_ff.tout));
    endsequence

    sequence s_idle_start(logic [2:0] code, logic src);
        ce && st_ff.state == IDLE && mode_legal && st_ff.mode.trigger_select == code && src;
    endsequence

    AST_SPLIT_RANGE: assert property (
        ce && st_ff.mode.width_split_select |=> (st_ff.count & ~MASK_SPLIT) == '0)
        else $error("split channel count left the 8-bit range");
    AST_SW_ONLY: assert property (
        ce && st_ff.state == IDLE && st_ff.mode.trigger_select == timer_mode_pkg::TRIG_SW
        && !sw_start |=> st_ff.state == IDLE)
        else $error("channel started without software start");
    AST_EDGE_START: assert property (
        s_idle_start(timer_mode_pkg::TRIG_EDGE, edges.valid_edge) |=> st_ff.state == RUN)
        else $error("valid pin edge did not start the channel");
    AST_MASTER_START: assert property (
        s_idle_start(timer_mode_pkg::TRIG_MASTER, master_irq) |=> st_ff.state == RUN)
        else $error("master interrupt did not start the channel");
    AST_INTERVAL_DOWN: assert property (
        ce && st_ff.state == RUN && op == timer_mode_pkg::OP_INTERVAL && !sw_stop && tick
        && st_ff.count != '0 |=> st_ff.count == (($past(st_ff.count) - CNT_ONE) & cnt_mask))
        else $error("interval mode did not count down");
    AST_CAPTURE_UP: assert property (
        ce && st_ff.state == RUN && op == timer_mode_pkg::OP_CAPTURE && !sw_stop && !hw_trig
        && tick && st_ff.count != cnt_mask |=> st_ff.count == $past(st_ff.count) + CNT_ONE)
        else $error("capture mode did not count up");
    AST_START_IRQ: assert property (
        ce && st_ff.state == IDLE && start_evt && opt && (op == timer_mode_pkg::OP_INTERVAL
        || op == timer_mode_pkg::OP_CAPTURE)
        |=> s_start_effect)
        else $error("start with option set gave no interrupt and toggle");
    AST_NO_START_IRQ: assert property (
        ce && st_ff.state == IDLE && start_evt && !opt |=> !st_ff.irq && $stable(st_ff.tout))
        else $error("start with option clear raised an interrupt");
    AST_ONE_IGNORE: assert property (
        ce && st_ff.state == RUN && op == timer_mode_pkg::OP_ONE && !opt && !sw_stop
        && start_evt && tick && st_ff.count != '0 |=> !st_ff.irq
        && st_ff.count == (($past(st_ff.count) - CNT_ONE) & cnt_mask))
        else $error("one-count retrigger was not ignored");
    AST_ONE_RETRIG: assert property (
        ce && st_ff.state == RUN && op == timer_mode_pkg::OP_ONE && opt && !sw_stop
        && start_evt |=> st_ff.irq && st_ff.count == $past(reload))
        else $error("one-count retrigger did not restart with interrupt");
    AST_PIN_CLOCK: assert property (
        ce && st_ff.state == RUN && op == timer_mode_pkg::OP_INTERVAL && !sw_stop
        && st_ff.mode.count_clock_select && !edges.valid_edge |=> $stable(st_ff.count))
        else $error("pin-clocked count moved without a valid edge");

endmodule

`default_nettype wire

/* File: timer_pin_partner.sv */
/* far-side model: channel input pin and master channel interrupt.
   assumes calls come from the bench's one process, right after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module timer_pin_partner
(
    input  wire logic aclk,
    output var  logic channel_input_pin,
    output var  logic master_irq
);
    // pin idles low, master interrupt idles inactive
    initial
    begin
        channel_input_pin = 1'b0;
        master_irq        = 1'b0;
    end
    // one-cycle pulse, same clock as the channel, so no synchroniser on it
    task automatic pulse_master();
        master_irq <= 1'b1;
        @(posedge aclk);
        master_irq <= 1'b0;
    endtask
    // level held 4 cycles so the two-flop synchroniser sees it
    task automatic set_pin(input logic v);
        channel_input_pin <= v;
        repeat (4) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

/* File: test_timer_channel_mode_control.sv */
/* self-checking bench for the timer channel mode control.
   assumes the partner model drives the pin and the master interrupt. */
`timescale 1ns/1ps
`default_nettype none
module test_timer_channel_mode_control;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, channel_input_pin, master_irq, timer_irq, timer_out;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
    int          num_errors, checked, cycles, irq_cnt, n;

    timer_channel_mode_control uut
    (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .channel_input_pin, .master_irq, .timer_irq, .timer_out
    );
    timer_pin_partner partner (.aclk, .channel_input_pin, .master_irq);

    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // interrupt pulses counted in the background; tests compare differences
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (timer_irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // only listed trigger and mode codes are built, edge select rising
    function automatic logic [31:0] mv(logic s, logic [2:0] t, logic [2:0] op, logic o);
        return {20'h0, s, t, 2'h1, 2'h0, op, o};
    endfunction
    task automatic go(input logic [31:0] m);
        wr(timer_mode_pkg::PERIOD_OFS, 32'h100);
        wr(timer_mode_pkg::MODE_OFS, m);
        n = irq_cnt;
        wr(timer_mode_pkg::CTRL_OFS, 32'h1);
    endtask
    task automatic t_reset();
        rd(timer_mode_pkg::MODE_OFS);
        chk(rd_data, 32'h0);
        rd(timer_mode_pkg::PERIOD_OFS);
        chk(rd_data, 32'hFFFF);
        rd(8'h40);
        chk(32'(rd_resp), 32'(timer_mode_pkg::RESP_SLVERR));
        $display("done reset");
    endtask
    // every mode, option clear: direction, running, no start irq, output still
    task automatic t_modes();
        logic [2:0] ops [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
        logic [2:0] st [5] = '{3'h1, 3'h5, 3'h1, 3'h1, 3'h5};
        for (int i = 0; i < 5; i++)
        begin
            go(mv(1'b0, timer_mode_pkg::TRIG_SW, ops[i], 1'b0));
            rd(timer_mode_pkg::STATUS_OFS);
            chk(32'(rd_data[2:0]), 32'(st[i]));
            chk(irq_cnt - n, 0);
            wr(timer_mode_pkg::CTRL_OFS, 32'h2);
        end
        $display("done modes");
    endtask
    task automatic t_start_irq();
        go(mv(1'b0, timer_mode_pkg::TRIG_SW, timer_mode_pkg::OP_CAPTURE, 1'b1));
        repeat (4) @(posedge aclk);
        chk(irq_cnt - n, 1);
        rd(timer_mode_pkg::STATUS_OFS);
        chk(32'(rd_data[1]), 32'h1);
        wr(timer_mode_pkg::CTRL_OFS, 32'h2);
        $display("done start irq");
    endtask
    // master starts, software select ignores master, rising pin, then falling
    task automatic t_triggers();
        logic [2:0] tr [4] = '{3'h4, 3'h0, 3'h1, 3'h2};
        logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        wr(timer_mode_pkg::PERIOD_OFS, 32'h100);
        for (int i = 0; i < 4; i++)
        begin
            wr(timer_mode_pkg::MODE_OFS, mv(1'b0, tr[i], timer_mode_pkg::OP_ONE, 1'b0));
            if (i < 2) partner.pulse_master();
            else partner.set_pin(~channel_input_pin);
            repeat (8) @(posedge aclk);
            rd(timer_mode_pkg::STATUS_OFS);
            chk(32'(rd_data[0]), 32'(ex[i]));
            wr(timer_mode_pkg::CTRL_OFS, 32'h2);
        end
        $display("done triggers");
    endtask
    // retrigger by master interrupt while one-count runs
    task automatic t_retrig();
        for (int o = 0; o < 2; o++)
        begin
            go(mv(1'b0, timer_mode_pkg::TRIG_MASTER, timer_mode_pkg::OP_ONE, o[0]));
            repeat (4) @(posedge aclk);
            n = irq_cnt;
            partner.pulse_master();
            repeat (6) @(posedge aclk);
            chk(irq_cnt - n, o);
            wr(timer_mode_pkg::CTRL_OFS, 32'h2);
        end
        $display("done retrigger");
    endtask
    // period 0x1FF: upper count byte shows whether 8 or 16 bits are kept
    task automatic t_split();
        for (int s = 0; s < 2; s++)
        begin
            wr(timer_mode_pkg::PERIOD_OFS, 32'h1FF);
            wr(timer_mode_pkg::MODE_OFS, mv(s[0], 3'h0, 3'h0, 1'b0));
            rd(timer_mode_pkg::MODE_OFS);
            chk(rd_data, mv(s[0], 3'h0, 3'h0, 1'b0));
            wr(timer_mode_pkg::CTRL_OFS, 32'h1);
            rd(timer_mode_pkg::COUNT_OFS);
            chk(32'(rd_data[15:8]), 32'(1 - s));
            wr(timer_mode_pkg::CTRL_OFS, 32'h2);
        end
        $display("done split");
    endtask
    // count clock from the pin
    task automatic t_pin_clk();
        go(mv(1'b0, 3'h0, 3'h0, 1'b0) | 32'h1000);
        rd(timer_mode_pkg::COUNT_OFS);
        chk(rd_data, 32'h100);
        partner.set_pin(1'b1);
        rd(timer_mode_pkg::COUNT_OFS);
        chk(rd_data, 32'hFF);
        wr(timer_mode_pkg::CTRL_OFS, 32'h2);
        $display("done pin");
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_modes();
        t_start_irq();
        t_triggers();
        t_retrig();
        t_split();
        t_pin_clk();
        report_and_stop();
    end
endmodule
`default_nettype wire
